// [hw/sc_serial_ctrl.sv]
/*
 Serial control and status logic: register file on classic Wishbone,
 transmitter with preamble and break, oversampling receiver, status flags
 and three interrupt request outputs. Assumes txd_o/rxd_i go to pins and
 rxd_i is asynchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module sc_serial_ctrl (
   input  wire logic        clk_i,      // 40 MHz clock
   input  wire logic        rst_i,      // sync reset, high
   input  wire logic        wb_cyc_i,   // bus cycle
   input  wire logic        wb_stb_i,   // strobe
   input  wire logic        wb_we_i,    // write
   input  wire logic [7:0]  wb_adr_i,   // byte address
   input  wire logic [3:0]  wb_sel_i,   // byte lanes
   input  wire logic [31:0] wb_dat_i,   // write data
   output logic      [31:0] wb_dat_o,   // read data
   output logic             wb_ack_o,   // acknowledge
   input  wire logic        rxd_i,      // serial in, async
   output logic             txd_o,      // serial out
   output logic             tx_irq_o,   // transmitter request
   output logic             rx_irq_o,   // receiver request
   output logic             err_irq_o   // error request
);
   typedef enum logic {TX_IDLE, TX_SEND} sc_tx_t;
   typedef enum logic {RX_IDLE, RX_BITS} sc_rx_t;
   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
      logic        txd;
      logic        tx_irq;
      logic        rx_irq;
      logic        err_irq;
      logic [7:0]  c1;
      logic [7:0]  c2;
      logic        tx9;
      logic [3:0]  eie;
      logic        rx9;
      logic        txe;
      logic        tc;
      logic        full;
      logic        quiet;
      logic        ovr;
      logic        nse;
      logic        fe;
      logic        pe;
      logic        arm_txe;
      logic [5:0]  arm_rx;
      logic [15:0] div;
      logic [15:0] osc;
      logic [7:0]  txbuf;
      logic [7:0]  rxbuf;
      sc_tx_t      txs;
      logic [10:0] tsh;
      logic [3:0]  tcnt;
      logic [3:0]  tph;
      logic        pre;
      logic        tail;
      logic        rx_m;
      logic        rx_s;
      sc_rx_t      rxs;
      logic [3:0]  rph;
      logic [3:0]  ridx;
      logic [1:0]  smp;
      logic [8:0]  rsh;
      logic        nz;
      logic [7:0]  icnt;
      logic        qarm;
   } sc_st_t;

   sc_st_t s_r;
   sc_st_t s_nxt;

   // parity over nine bits, odd selects odd sense
   function automatic logic sc_par(input logic [8:0] v, input logic odd);
      sc_par = (^v) ^ odd;
   endfunction

   // one state register, everything else is next-state logic
   always_ff @(posedge clk_i) begin
      s_r <= s_nxt;
   end

   assign wb_dat_o  = s_r.dat;
   assign wb_ack_o  = s_r.ack;
   assign txd_o     = s_r.txd;
   assign tx_irq_o  = s_r.tx_irq;
   assign rx_irq_o  = s_r.rx_irq;
   assign err_irq_o = s_r.err_irq;

   always_comb begin
      logic       req;
      logic       wr;
      logic       rd;
      logic       mod_on;
      logic       m9;
      logic       os_tick;
      logic       bit_tick;
      logic       free;
      logic [3:0] clen;
      logic [7:0] deff;
      logic       b8;
      logic [2:0] sv;
      logic       vote;
      logic [8:0] d9;
      logic       msb;
      logic       perr;
      logic       brk_go;
      req      = 1'b0;
      wr       = 1'b0;
      rd       = 1'b0;
      mod_on   = 1'b0;
      m9       = 1'b0;
      os_tick  = 1'b0;
      bit_tick = 1'b0;
      free     = 1'b0;
      clen     = sc_pkg::CHAR8;
      deff     = 8'h00;
      b8       = 1'b0;
      sv       = 3'h0;
      vote     = 1'b0;
      d9       = 9'h000;
      msb      = 1'b0;
      perr     = 1'b0;
      brk_go   = 1'b0;
      s_nxt    = s_r;

      // bus slave: one wait state, ack drops the cycle after
      req       = wb_cyc_i & wb_stb_i & ~s_r.ack;
      wr        = req & wb_we_i;
      rd        = req & ~wb_we_i;
      s_nxt.ack = req;
      if (rd) begin
         s_nxt.dat = 32'h0000_0000;
         case (wb_adr_i)
            sc_pkg::ADR_CTRL1: s_nxt.dat[7:0] = s_r.c1;
            sc_pkg::ADR_CTRL2: s_nxt.dat[7:0] = s_r.c2;
            sc_pkg::ADR_CTRL3: s_nxt.dat[7:0] = {s_r.rx9, s_r.tx9, 2'b00, s_r.eie};
            sc_pkg::ADR_STAT1: begin
               s_nxt.dat[7:0] = {s_r.txe, s_r.tc, s_r.full, s_r.quiet,
                                 s_r.ovr, s_r.nse, s_r.fe, s_r.pe};
               // remember which flags software has seen set
               s_nxt.arm_txe = s_r.txe;
               s_nxt.arm_rx  = {s_r.full, s_r.quiet, s_r.ovr,
                                s_r.nse, s_r.fe, s_r.pe};
            end
            sc_pkg::ADR_DATA: begin
               s_nxt.dat[7:0] = s_r.rxbuf;
               // second step of the clearing sequence
               if (s_r.arm_rx[5]) s_nxt.full  = 1'b0;
               if (s_r.arm_rx[4]) s_nxt.quiet = 1'b0;
               if (s_r.arm_rx[3]) s_nxt.ovr   = 1'b0;
               if (s_r.arm_rx[2]) s_nxt.nse   = 1'b0;
               if (s_r.arm_rx[1]) s_nxt.fe    = 1'b0;
               if (s_r.arm_rx[0]) s_nxt.pe    = 1'b0;
               s_nxt.arm_rx = 6'h00;
            end
            sc_pkg::ADR_BAUD: s_nxt.dat[15:0] = s_r.div;
            default: s_nxt.dat = 32'h0000_0000;
         endcase
      end
      if (wr && wb_sel_i[0]) begin
         case (wb_adr_i)
            sc_pkg::ADR_CTRL1: s_nxt.c1 = wb_dat_i[7:0];
            sc_pkg::ADR_CTRL2: begin
               s_nxt.c2[7:4] = wb_dat_i[7:4];
               s_nxt.c2[1:0] = wb_dat_i[1:0];
               // tx_on and rx_on only move while the module is on
               if (s_r.c1[sc_pkg::C1_MODON]) begin
                  s_nxt.c2[3:2] = wb_dat_i[3:2];
                  // each rising tx_on queues a preamble or idle
                  if (wb_dat_i[3] && !s_r.c2[sc_pkg::C2_TXON])
                     s_nxt.pre = 1'b1;
                  if (wb_dat_i[2] && !s_r.c2[sc_pkg::C2_RXON])
                     s_nxt.qarm = 1'b0;
               end
            end
            sc_pkg::ADR_CTRL3: begin
               s_nxt.tx9 = wb_dat_i[sc_pkg::C3_TX9];
               s_nxt.eie = wb_dat_i[3:0];
            end
            sc_pkg::ADR_DATA: begin
               s_nxt.txbuf = wb_dat_i[7:0];
               if (s_r.arm_txe) s_nxt.txe = 1'b0;
               s_nxt.arm_txe = 1'b0;
            end
            default: s_nxt.div[7:0] = (wb_adr_i == sc_pkg::ADR_BAUD) ?
                                      wb_dat_i[7:0] : s_r.div[7:0];
         endcase
      end
      if (wr && wb_sel_i[1] && wb_adr_i == sc_pkg::ADR_BAUD)
         s_nxt.div[15:8] = wb_dat_i[15:8];

      // settings shared by both directions; module off acts in the same cycle
      mod_on = s_nxt.c1[sc_pkg::C1_MODON];
      m9     = s_r.c1[sc_pkg::C1_MODE9];
      clen   = m9 ? sc_pkg::CHAR9 : sc_pkg::CHAR8;

      // oversampling tick, sixteen per bit; stopped while off
      if (!mod_on || s_r.osc >= s_r.div) begin
         s_nxt.osc = 16'h0000;
         os_tick   = mod_on;
      end else begin
         s_nxt.osc = s_r.osc + 16'h0001;
      end

      // transmitter bit timing
      if (os_tick && s_r.txs == TX_SEND) begin
         s_nxt.tph = s_r.tph + 4'h1;
         bit_tick  = (s_r.tph == sc_pkg::OS_LAST);
      end
      if (bit_tick) begin
         s_nxt.tsh  = {1'b1, s_r.tsh[10:1]};
         s_nxt.tcnt = s_r.tcnt - 4'h1;
      end
      // ends the character in progress even when tx_on went low
      free = (s_r.txs == TX_IDLE) || (bit_tick && s_r.tcnt == 4'h1);
      brk_go = s_nxt.c2[sc_pkg::C2_TXON] & s_nxt.c2[sc_pkg::C2_BRK];

      // frame content, parity takes the msb position
      deff = s_nxt.txbuf;
      b8   = s_nxt.tx9;
      if (s_nxt.c1[sc_pkg::C1_PAREN]) begin
         if (m9) b8 = sc_par({1'b0, deff}, s_nxt.c1[sc_pkg::C1_PARODD]);
         else deff[7] = sc_par({2'b00, deff[6:0]}, s_nxt.c1[sc_pkg::C1_PARODD]);
      end

      // next job: break beats tail, preamble and data
      if (free && mod_on) begin
         s_nxt.tph = 4'h0;
         if (brk_go) begin
            s_nxt.txs  = TX_SEND;
            s_nxt.tsh  = 11'h000;
            s_nxt.tcnt = clen;
            s_nxt.tail = 1'b1;
            s_nxt.pre  = 1'b0;
         end else if (s_nxt.tail) begin
            s_nxt.txs  = TX_SEND;
            s_nxt.tsh  = 11'h7ff;
            s_nxt.tcnt = 4'h1;
            s_nxt.tail = 1'b0;
         end else if (s_nxt.pre && s_nxt.c2[sc_pkg::C2_TXON]) begin
            s_nxt.txs  = TX_SEND;
            s_nxt.tsh  = 11'h7ff;
            s_nxt.tcnt = clen;
            s_nxt.pre  = 1'b0;
         // data leaves only once software has cleared tx_empty
         end else if (s_nxt.c2[sc_pkg::C2_TXON] && !s_nxt.txe) begin
            s_nxt.txs  = TX_SEND;
            s_nxt.tsh  = m9 ? {1'b1, b8, deff, 1'b0} : {2'b11, deff, 1'b0};
            s_nxt.tcnt = clen;
            s_nxt.txe  = 1'b1;
         end else begin
            s_nxt.txs  = TX_IDLE;
         end
      end
      if (!mod_on) begin
         s_nxt.txs = TX_IDLE;
         s_nxt.txe = 1'b1;
      end
      // idle line is high
      s_nxt.txd = (s_nxt.txs == TX_SEND) ? s_nxt.tsh[0] : 1'b1;
      s_nxt.tc  = s_nxt.txe && s_nxt.txs == TX_IDLE && !s_nxt.tail &&
                  !(s_nxt.pre && s_nxt.c2[sc_pkg::C2_TXON]) && !brk_go;
      if (!mod_on) s_nxt.tc = 1'b1;

      // receive pin synchroniser
      s_nxt.rx_m = rxd_i;
      s_nxt.rx_s = s_r.rx_m;

      // idle counter: oversampling ticks of high line between characters
      if (s_r.rx_s == 1'b0 || s_r.rxs == RX_BITS || !s_r.c2[sc_pkg::C2_RXON]) begin
         s_nxt.icnt = 8'h00;
      end else if (os_tick) begin
         if (s_r.icnt != 8'hff) s_nxt.icnt = s_r.icnt + 8'h01;
         if (s_r.icnt == (m9 ? sc_pkg::IDLE9 : sc_pkg::IDLE8)) begin
            if (s_r.qarm) begin
               s_nxt.quiet = 1'b1;
               s_nxt.qarm  = 1'b0;
            end
            if (!s_r.c1[sc_pkg::C1_WAKEA])
               s_nxt.c2[sc_pkg::C2_STBY] = 1'b0;
         end
      end

      // receiver, majority of three samples near mid-bit
      if (!s_r.c2[sc_pkg::C2_RXON]) begin
         s_nxt.rxs = RX_IDLE;
      end else if (os_tick) begin
         case (s_r.rxs)
            RX_IDLE: begin
               if (!s_r.rx_s) begin
                  s_nxt.rxs  = RX_BITS;
                  s_nxt.rph  = 4'h0;
                  s_nxt.ridx = 4'h0;
                  s_nxt.nz   = 1'b0;
               end
            end
            RX_BITS: begin
               s_nxt.rph = s_r.rph + 4'h1;
               if (s_r.rph == sc_pkg::SMP_A || s_r.rph == sc_pkg::SMP_B)
                  s_nxt.smp = {s_r.smp[0], s_r.rx_s};
               if (s_r.rph == sc_pkg::SMP_C) begin
                  sv   = {s_r.smp, s_r.rx_s};
                  vote = (sv[0] & sv[1]) | (sv[0] & sv[2]) | (sv[1] & sv[2]);
                  s_nxt.nz   = s_r.nz | ~((&sv) | ~(|sv));
                  s_nxt.ridx = s_r.ridx + 4'h1;
                  // a high start sample is a glitch, go back to hunting
                  if (s_r.ridx == 4'h0 && vote) begin
                     s_nxt.rxs = RX_IDLE;
                  end else if (s_r.ridx == clen - 4'h1) begin
                     s_nxt.rxs = RX_IDLE;
                     d9   = m9 ? s_r.rsh : {1'b0, s_r.rsh[8:1]};
                     msb  = m9 ? d9[8] : d9[7];
                     perr = s_r.c1[sc_pkg::C1_PAREN] &&
                            sc_par(m9 ? d9 : {1'b0, d9[7:0]}, s_r.c1[sc_pkg::C1_PARODD]);
                     if (s_r.c2[sc_pkg::C2_STBY] && s_r.c1[sc_pkg::C1_WAKEA] && msb)
                        s_nxt.c2[sc_pkg::C2_STBY] = 1'b0;
                     // standby swallows the character and leaves every flag alone
                     if (s_nxt.c2[sc_pkg::C2_STBY]) begin
                        s_nxt.nz = 1'b0;
                     end else if (s_r.full) begin
                        s_nxt.ovr = 1'b1;
                     end else begin
                        s_nxt.rxbuf = d9[7:0];
                        s_nxt.rx9   = m9 ? d9[8] : d9[7];
                        s_nxt.full  = 1'b1;
                        s_nxt.qarm  = 1'b1;
                        if (s_nxt.nz) s_nxt.nse = 1'b1;
                        if (!vote) s_nxt.fe = 1'b1;
                        if (perr) s_nxt.pe = 1'b1;
                     end
                  end else begin
                     s_nxt.rsh = {vote, s_r.rsh[8:1]};
                  end
               end
            end
            default: s_nxt.rxs = RX_IDLE;
         endcase
      end

      // interrupt requests, registered
      s_nxt.tx_irq = mod_on &&
                     ((s_nxt.txe && s_nxt.c2[sc_pkg::C2_TXEIE]) ||
                      (s_nxt.tc && s_nxt.c2[sc_pkg::C2_TX_DONE_IRQ_ON]));
      s_nxt.rx_irq = !s_nxt.c2[sc_pkg::C2_STBY] &&
                     ((s_nxt.full && s_nxt.c2[sc_pkg::C2_RXFIE]) ||
                      (s_nxt.quiet && s_nxt.c2[sc_pkg::C2_QIE]));
      s_nxt.err_irq = |({s_nxt.ovr, s_nxt.nse, s_nxt.fe, s_nxt.pe} & s_nxt.eie);

      // reset keeps received data and the received ninth bit
      if (rst_i) begin
         s_nxt       = '0;
         s_nxt.c1    = sc_pkg::CTRL1_RST;
         s_nxt.c2    = sc_pkg::CTRL2_RST;
         s_nxt.txd   = 1'b1;
         s_nxt.txe   = 1'b1;
         s_nxt.tc    = 1'b1;
         s_nxt.div   = sc_pkg::BAUD_RST;
         s_nxt.txs   = TX_IDLE;
         s_nxt.rxs   = RX_IDLE;
         s_nxt.tsh   = 11'h7ff;
         s_nxt.rx_m  = 1'b1;
         s_nxt.rx_s  = 1'b1;
         s_nxt.rx9   = s_r.rx9;
         s_nxt.txbuf = s_r.txbuf;
         s_nxt.rxbuf = s_r.rxbuf;
      end
   end
endmodule
`default_nettype wire

// [shared/sc_pkg.sv]
/*
 Register map, field positions, reset values and timing counts for the
 serial control and status block. Assumes a 32-bit classic Wishbone bus
 with byte addresses, 8-bit registers in the low byte lane and a 16-bit baud divisor in the low two lanes.
*/
// Function
// - transmit-empty flag with its enable raises transmitter interrupt
// - transmit-done flag with its enable raises transmitter interrupt
// - receive-full or line-quiet flag with enable raises receiver interrupt
// - overrun, noise, framing or parity flag with enable raises error request
// - reset clears all interrupt enables, tx_on, rx_on, standby, send_brk
// - enabling transmitter first sends 10 or 11 ones as preamble
// - disabling transmitter finishes current character, then line idles high
// - off-then-on during a character queues one idle character afterwards
// - disabling receiver stops reception, receiver flags stay as they are
// - standby suppresses receiver interrupts; chosen wake event clears it
// - break bit pulse sends one break plus a one; held sends breaks back to back
// - received ninth bit: bit 8 in 9-bit mode, bit 7 copy otherwise, no reset
// - transmit ninth bit loads with the data; reset clears it
// - tx empty sets on hand-over, clears by status read then data write
// - tx done set when empty and nothing sent; clears once something is queued
// - rx full sets on transfer, clears by status read then data read
// - line quiet after 10/11 ones, armed only by a fresh received character
// - overrun keeps old data, drops new, clears by seen status then data read
// - noise and parity flags set on detection, cleared by status then data read
// - framing flag set on zero stop bit, cleared by status then data read
// - module off forces tx empty and tx done high, masks transmitter interrupts
// - wake method: 1 address mark in msb, 0 idle line
`default_nettype none
package sc_pkg;
   // byte addresses, one word each
   localparam logic [7:0]  ADR_CTRL1  = 8'h00;
   localparam logic [7:0]  ADR_CTRL2  = 8'h04;
   localparam logic [7:0]  ADR_CTRL3  = 8'h08;
   localparam logic [7:0]  ADR_STAT1  = 8'h0c;
   localparam logic [7:0]  ADR_DATA   = 8'h10;
   localparam logic [7:0]  ADR_BAUD   = 8'h14;
   // control one fields
   localparam int C1_MODON = 6;
   localparam int C1_MODE9 = 4;
   localparam int C1_WAKEA = 3;
   localparam int C1_PAREN = 1;
   localparam int C1_PARODD = 0;
   // control two fields
   localparam int C2_TXEIE = 7;
   localparam int C2_TX_DONE_IRQ_ON  = 6;
   localparam int C2_RXFIE = 5;
   localparam int C2_QIE   = 4;
   localparam int C2_TXON  = 3;
   localparam int C2_RXON  = 2;
   localparam int C2_STBY  = 1;
   localparam int C2_BRK   = 0;
   // control three fields, error enables in bits 3..0
   localparam int C3_RX9 = 7;
   localparam int C3_TX9 = 6;
   // reset values
   localparam logic [7:0]  CTRL1_RST = 8'h00;
   localparam logic [7:0]  CTRL2_RST = 8'h00;
   localparam logic [15:0] BAUD_RST  = 16'h0015;
   // oversampling and character timing
   localparam logic [3:0]  OS_LAST   = 4'hf;
   localparam logic [3:0]  SMP_A     = 4'h7;
   localparam logic [3:0]  SMP_B     = 4'h8;
   localparam logic [3:0]  SMP_C     = 4'h9;
   localparam logic [3:0]  CHAR8     = 4'ha;
   localparam logic [3:0]  CHAR9     = 4'hb;
   localparam logic [7:0]  IDLE8     = 8'h9f;
   localparam logic [7:0]  IDLE9     = 8'haf;
endpackage
`default_nettype wire

// [tb/sc_assertions.sv]
/*
 Checker for sc_serial_ctrl: bus handshake, reset state, interrupt
 requests against status and enables, module-off state.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module sc_assertions (
   input wire logic        clk_i,     // clock
   input wire logic        rst_i,     // sync reset
   input wire logic        wb_cyc_i,  // bus cycle
   input wire logic        wb_stb_i,  // strobe
   input wire logic        wb_we_i,   // write
   input wire logic [7:0]  wb_adr_i,  // address
   input wire logic [3:0]  wb_sel_i,  // lanes
   input wire logic [31:0] wb_dat_i,  // write data
   input wire logic [31:0] wb_dat_o,  // read data
   input wire logic        wb_ack_o,  // acknowledge
   input wire logic        rxd_i,     // serial in
   input wire logic        txd_o,     // serial out
   input wire logic        tx_irq_o,  // tx request
   input wire logic        rx_irq_o,  // rx request
   input wire logic        err_irq_o  // error request
);
   logic       mod_on_r;
   logic [7:0] c2_r;
   logic [3:0] c3_r;
   logic       wr_ok;
   // shadow of written bits; hardware only ever clears standby, so 0 is exact
   assign wr_ok = wb_cyc_i & wb_stb_i & !wb_ack_o & wb_we_i & wb_sel_i[0];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mod_on_r <= 1'b0;
         c2_r     <= 8'h00;
         c3_r     <= 4'h0;
      end else if (wr_ok) begin
         if (wb_adr_i == sc_pkg::ADR_CTRL1) mod_on_r <= wb_dat_i[sc_pkg::C1_MODON];
         if (wb_adr_i == sc_pkg::ADR_CTRL2) c2_r <= wb_dat_i[7:0];
         if (wb_adr_i == sc_pkg::ADR_CTRL3) c3_r <= wb_dat_i[3:0];
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence take_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence stat_rd_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == sc_pkg::ADR_STAT1;
   endsequence
   ack_latency_a: assert property (take_s |=> wb_ack_o)
      else $error("no ack one cycle after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   reset_quiet_a: assert property ($past(rst_i) |-> !tx_irq_o && !rx_irq_o && !err_irq_o && txd_o)
      else $error("requests or line active after reset");
   unmapped_zero_a: assert property ((take_s ##0 !wb_we_i && wb_adr_i == 8'h18) |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   off_flags_a: assert property ((stat_rd_s ##0 !mod_on_r) |=> wb_dat_o[7:6] == 2'b11)
      else $error("tx flags not forced while off");
   off_idle_a: assert property (!mod_on_r && !$past(mod_on_r) |-> txd_o && !tx_irq_o)
      else $error("line or tx request active while off");
   tx_irq_match_a: assert property (stat_rd_s |=> $past(tx_irq_o) == (mod_on_r &&
      (wb_dat_o[7] && c2_r[7] || wb_dat_o[6] && c2_r[6]))) else $error("tx request mismatch");
   rx_irq_match_a: assert property ((stat_rd_s ##0 !c2_r[1]) |=> $past(rx_irq_o) ==
      (wb_dat_o[5] && c2_r[5] || wb_dat_o[4] && c2_r[4])) else $error("rx request mismatch");
   err_irq_match_a: assert property (stat_rd_s |=> $past(err_irq_o) ==
      |(wb_dat_o[3:0] & c3_r)) else $error("error request mismatch");
endmodule
bind sc_serial_ctrl sc_assertions chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxd_i(rxd_i),
   .txd_o(txd_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o), .err_irq_o(err_irq_o));
`default_nettype wire

// [tb/sc_remote_node.sv]
/*
 Remote serial node: sends 8N1 frames into the block and samples
 frames leaving it. Assumes one bit lasts BIT_CLKS clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module sc_remote_node #(parameter int BIT_CLKS = 16) (
   input  wire logic clk_i,  // shared clock
   input  wire logic txd_i,  // line from the block
   output logic      rxd_o   // line into the block
);
   initial rxd_o = 1'b1;
   // lsb first; the line returns to its high idle level after the stop bit
   task automatic send_char(input logic [7:0] d, input logic stop);
      logic [9:0] f;
      f = {stop, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd_o <= f[i];
         repeat (BIT_CLKS) @(posedge clk_i);
      end
      // one idle cycle so a following start bit is a separate edge
      rxd_o <= 1'b1;
      @(posedge clk_i);
   endtask
   // waits a bounded time for a start bit, then samples mid-cell
   task automatic recv_char(output logic [7:0] d, output logic stop, output int gap);
      gap = 0;
      while (txd_i !== 1'b0 && gap < 4000) begin
         @(posedge clk_i);
         gap++;
      end
      repeat (BIT_CLKS / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CLKS) @(posedge clk_i);
         d[i] = txd_i;
      end
      repeat (BIT_CLKS) @(posedge clk_i);
      stop = txd_i;
   endtask
endmodule
`default_nettype wire

// [tb/sc_serial_ctrl_bench.sv]
/*
 Bench for sc_serial_ctrl: register reads and writes over classic
 Wishbone, frames through the remote node, flag checks.
 Assumes baud divisor 0, so one bit lasts 16 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module sc_serial_ctrl_bench;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]  wb_adr_i, rx_d;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic        rxd_i, txd_o, tx_irq_o, rx_irq_o, err_irq_o, rx_stop;
   int          fail_count = 0;
   int          check_count = 0;
   int          gap;
   sc_serial_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxd_i(rxd_i),
      .txd_o(txd_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o), .err_irq_o(err_irq_o));
   sc_remote_node node (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i));
   // 40 MHz
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // one classic cycle, held until ack is sampled; a lost ack counts as a mismatch
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                       output logic [31:0] rd);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_sel_i <= 4'h3;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) fail_count++;
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] adr, input logic [15:0] d);
      logic [31:0] x;
      xfer(1'b1, adr, {16'h0000, d}, x);
   endtask
   // masked compare of an 8-bit register
   task automatic rd(input logic [7:0] adr, input logic [7:0] mask, input logic [7:0] exp);
      logic [31:0] x;
      xfer(1'b0, adr, 32'h0000_0000, x);
      check(x & {24'h00_0000, mask}, {24'h00_0000, exp});
   endtask
   // watchdog well beyond the under two thousand cycles the tests take
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      give_verdict();
   end
   initial begin
      rst_i    = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i  = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h3;
      wb_dat_i = 32'h0000_0000;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // reset state, then refused enables while the module is off
      rd(sc_pkg::ADR_CTRL2, 8'hff, sc_pkg::CTRL2_RST);
      rd(sc_pkg::ADR_CTRL3, 8'h7f, 8'h00);
      rd(sc_pkg::ADR_STAT1, 8'hff, 8'hc0);
      rd(8'h18, 8'hff, 8'h00);
      wr(sc_pkg::ADR_CTRL2, 16'h000c);
      rd(sc_pkg::ADR_CTRL2, 8'h0c, 8'h00);
      wr(sc_pkg::ADR_BAUD, 16'h0000);
      wr(sc_pkg::ADR_CTRL1, 16'h0040);
      wr(sc_pkg::ADR_CTRL3, 16'h000f);
      wr(sc_pkg::ADR_CTRL2, 16'h00f4);
      // two characters left unread: the second is dropped
      node.send_char(8'ha5, 1'b1);
      node.send_char(8'h5a, 1'b1);
      repeat (8) @(posedge clk_i);
      rd(sc_pkg::ADR_STAT1, 8'h2f, 8'h28);
      rd(sc_pkg::ADR_DATA, 8'hff, 8'ha5);
      rd(sc_pkg::ADR_CTRL3, 8'h80, 8'h80);
      rd(sc_pkg::ADR_STAT1, 8'h28, 8'h00);
      // zero stop bit, then a quiet line; flags survive receiver disable
      node.send_char(8'h81, 1'b0);
      repeat (220) @(posedge clk_i);
      wr(sc_pkg::ADR_CTRL2, 16'h00f0);
      rd(sc_pkg::ADR_STAT1, 8'h3f, 8'h32);
      rd(sc_pkg::ADR_DATA, 8'hff, 8'h81);
      rd(sc_pkg::ADR_STAT1, 8'h3f, 8'h00);
      // address-mark wake: plain character swallowed, marked one wakes and lands
      wr(sc_pkg::ADR_CTRL1, 16'h0048);
      wr(sc_pkg::ADR_CTRL2, 16'h0006);
      node.send_char(8'h12, 1'b1);
      node.send_char(8'h92, 1'b1);
      repeat (8) @(posedge clk_i);
      rd(sc_pkg::ADR_CTRL2, 8'h02, 8'h00);
      rd(sc_pkg::ADR_STAT1, 8'h2f, 8'h20);
      rd(sc_pkg::ADR_DATA, 8'hff, 8'h92);
      // transmit: preamble first, the byte goes out after it; break left alone meanwhile
      wr(sc_pkg::ADR_CTRL2, 16'h0008);
      rd(sc_pkg::ADR_STAT1, 8'hc0, 8'h80);
      wr(sc_pkg::ADR_DATA, 16'h00c3);
      rd(sc_pkg::ADR_STAT1, 8'hc0, 8'h00);
      node.recv_char(rx_d, rx_stop, gap);
      check({23'h0, rx_stop, rx_d}, 32'h0000_01c3);
      check(32'(gap >= 140 && gap <= 200), 32'h1);
      repeat (24) @(posedge clk_i);
      rd(sc_pkg::ADR_STAT1, 8'hc0, 8'hc0);
      // pulse of the break bit: one break character then a one
      wr(sc_pkg::ADR_CTRL2, 16'h0009);
      wr(sc_pkg::ADR_CTRL2, 16'h0008);
      node.recv_char(rx_d, rx_stop, gap);
      check({23'h0, rx_stop, rx_d}, 32'h0000_0000);
      repeat (16) @(posedge clk_i);
      check({31'h0, txd_o}, 32'h1);
      give_verdict();
   end
endmodule
`default_nettype wire
